// ### hw/dts_mem.sv
// byte-wide array for the memory target
// assumes write and read controls are registered by the caller
`timescale 1ns/100ps
`default_nettype none
module dts_mem (
    input  wire logic                       clk_i,
    input  wire logic                       we_i,
    input  wire logic [dts_pkg::MEM_AW-1:0] waddr_i,
    input  wire logic [7:0]                 wdata_i,
    input  wire logic [dts_pkg::MEM_AW-1:0] raddr_i,
    output logic      [7:0]                 rdata_o
);
    import dts_pkg::*;

    logic [7:0] arr [MEM_DEPTH];

    // read data registered; contents have no reset
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            arr[waddr_i] <= wdata_i;
        end
        rdata_o <= arr[raddr_i];
    end
endmodule : dts_mem
`default_nettype wire

// ### hw/dts_slave.sv
// two-wire slave answering a memory target and a register target
// assumes scl/sda/select pins asynchronous; register file outside on clk_i
`timescale 1ns/100ps
`default_nettype none
module dts_slave (
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic                       scl_i,
    input  wire logic                       sda_i,
    output logic                            sda_o,
    output logic                            sda_oe_n_o,
    input  wire logic [1:0]                 sel_i,
    output logic      [dts_pkg::REG_AW-1:0] reg_addr_o,
    output logic      [7:0]                 reg_wdata_o,
    output logic                            reg_we_o,
    input  wire logic [7:0]                 reg_rdata_i
);
    import dts_pkg::*;

    typedef struct packed {
        logic [2:0]        scl_sh;
        logic [2:0]        sda_sh;
        logic [5:0]        sel_sh;
        logic              scl_f;
        logic              sda_f;
        logic [1:0]        sel_f;
        dts_st_t           st;
        dts_kind_t         kind;
        logic [2:0]        cnt;
        logic [7:0]        sh;
        logic              tgt_reg;
        logic              rd;
        logic [6:0]        ahi;
        logic [MEM_AW-1:0] mem_addr;
        logic [MEM_AW-1:0] wr_addr;
        logic [REG_AW-1:0] reg_addr;
        logic              mem_we;
        logic              reg_we;
        logic [7:0]        wdata;
        logic              sda_rel;
    } dts_state_t;

    dts_state_t q;
    dts_state_t n;
    logic [7:0] mem_rdata;
    logic [7:0] rd_sel;
    logic [7:0] byte_in;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic       load_now;

    function automatic logic slave_hit(input logic [7:0] b, input logic [1:0] sel);
        slave_hit = (b[7:4] == MEM_ID || b[7:4] == REG_ID) && (b[2:1] == sel);
    endfunction : slave_hit

    function automatic logic [REG_AW-1:0] reg_inc(input logic [REG_AW-1:0] a);
        reg_inc = (a == REG_ADDR_TOP) ? REG_ADDR_RST : a + 5'h01;
    endfunction : reg_inc

    function automatic dts_kind_t next_kind(input dts_kind_t k, input logic tr);
        case (k)
            KD_SLV:  next_kind = tr ? KD_RA : KD_AH;
            KD_AH:   next_kind = KD_AL;
            default: next_kind = KD_DAT;
        endcase
    endfunction : next_kind

    dts_mem u_mem (
        .clk_i   (clk_i),
        .we_i    (q.mem_we),
        .waddr_i (q.wr_addr),
        .wdata_i (q.wdata),
        .raddr_i (q.mem_addr),
        .rdata_o (mem_rdata)
    );

    // ----------------------------------------------------------
    // next state
    // ----------------------------------------------------------
    always_comb begin
        n          = q;
        n.mem_we   = 1'b0;
        n.reg_we   = 1'b0;
        // first flop feeds only the second
        n.scl_sh   = {q.scl_sh[1:0], scl_i};
        n.sda_sh   = {q.sda_sh[1:0], sda_i};
        n.sel_sh   = {q.sel_sh[3:0], sel_i};
        if (q.scl_sh[1] == q.scl_sh[2]) begin
            n.scl_f = q.scl_sh[2];
        end
        if (q.sda_sh[1] == q.sda_sh[2]) begin
            n.sda_f = q.sda_sh[2];
        end
        if (q.sel_sh[3:2] == q.sel_sh[5:4]) begin
            n.sel_f = q.sel_sh[5:4];
        end
        rise     = n.scl_f & ~q.scl_f;
        fall     = ~n.scl_f & q.scl_f;
        start    = q.sda_f & ~n.sda_f & n.scl_f & q.scl_f;
        stop     = ~q.sda_f & n.sda_f & n.scl_f & q.scl_f;
        byte_in  = {q.sh[6:0], n.sda_f};
        rd_sel   = q.tgt_reg ? reg_rdata_i : mem_rdata;
        load_now = fall && ((q.st == ST_ACK && q.kind == KD_SLV && q.rd) || q.st == ST_LD);
        if (start) begin
            // abort whatever runs, a pending write included
            n.st      = ST_RX;
            n.kind    = KD_SLV;
            n.cnt     = CNT_RST;
            n.sda_rel = 1'b1;
        end else if (stop) begin
            n.st      = ST_IDLE;
            n.sda_rel = 1'b1;
        end else if (load_now) begin
            // first bit goes out on the fall after the acknowledge
            n.sh      = {rd_sel[6:0], 1'b0};
            n.sda_rel = rd_sel[7];
            n.cnt     = 3'h1;
            n.st      = ST_TX;
        end else begin
            case (q.st)
                ST_RX: begin
                    if (rise) begin
                        n.sh  = byte_in;
                        n.cnt = q.cnt + 3'h1;
                        if (q.cnt == BIT_LAST) begin
                            n.st = ST_ACKW;
                            case (q.kind)
                                KD_SLV: begin
                                    if (slave_hit(byte_in, q.sel_f)) begin
                                        n.tgt_reg = (byte_in[7:4] == REG_ID);
                                        n.rd      = byte_in[0];
                                    end else begin
                                        n.st = ST_IDLE;
                                    end
                                end
                                KD_AH: begin
                                    n.ahi = byte_in[6:0];
                                end
                                KD_AL: begin
                                    n.mem_addr = {q.ahi, byte_in};
                                end
                                KD_RA: begin
                                    if (byte_in > REG_ADDR_MAX) begin
                                        n.st = ST_IDLE;
                                    end else begin
                                        n.reg_addr = byte_in[REG_AW-1:0];
                                    end
                                end
                                default: begin
                                    n.wdata = byte_in;
                                    if (q.tgt_reg) begin
                                        n.reg_we   = 1'b1;
                                        n.reg_addr = reg_inc(q.reg_addr);
                                    end else begin
                                        // whole byte in hand before the array moves
                                        n.mem_we   = 1'b1;
                                        n.wr_addr  = q.mem_addr;
                                        n.mem_addr = q.mem_addr + 15'h0001;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_ACKW: begin
                    if (fall) begin
                        n.st      = ST_ACK;
                        n.sda_rel = 1'b0;
                    end
                end
                ST_ACK: begin
                    if (fall) begin
                        n.sda_rel = 1'b1;
                        n.cnt     = CNT_RST;
                        n.st      = ST_RX;
                        n.kind    = next_kind(q.kind, q.tgt_reg);
                    end
                end
                ST_TX: begin
                    if (rise && q.cnt == CNT_RST) begin
                        if (q.tgt_reg) begin
                            n.reg_addr = reg_inc(q.reg_addr);
                        end else begin
                            n.mem_addr = q.mem_addr + 15'h0001;
                        end
                    end
                    if (fall) begin
                        if (q.cnt == CNT_RST) begin
                            n.sda_rel = 1'b1;
                            n.st      = ST_MACK;
                        end else begin
                            n.sda_rel = q.sh[7];
                            n.sh      = {q.sh[6:0], 1'b0};
                            n.cnt     = q.cnt + 3'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (rise) begin
                        // master keeps high on the last byte it wants
                        n.st = n.sda_f ? ST_IDLE : ST_LD;
                    end
                end
                ST_LD: begin
                    n.st = ST_LD;
                end
                default: begin
                    n.st = ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------
    // state register
    // ----------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q          <= '0;
            q.scl_sh   <= '1;
            q.sda_sh   <= '1;
            q.scl_f    <= LINE_RST;
            q.sda_f    <= LINE_RST;
            q.st       <= ST_IDLE;
            q.kind     <= KD_SLV;
            q.cnt      <= CNT_RST;
            q.mem_addr <= MEM_ADDR_RST;
            q.reg_addr <= REG_ADDR_RST;
            q.sda_rel  <= LINE_RST;
        end else begin
            q <= n;
        end
    end

    // open drain: level and enable share one flop
    assign sda_o       = q.sda_rel;
    assign sda_oe_n_o  = q.sda_rel;
    assign reg_addr_o  = q.reg_addr;
    assign reg_wdata_o = q.wdata;
    assign reg_we_o    = q.reg_we;

    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_last_bit_in;
        q.st == ST_RX && rise && q.cnt == BIT_LAST && !start && !stop;
    endsequence

    sequence s_rd_addr_acked;
        q.st == ST_ACK && q.kind == KD_SLV && q.rd && fall && !start && !stop;
    endsequence

    AST_START_ABORT: assert property (start |=> q.st == ST_RX && q.kind == KD_SLV && q.sda_rel)
        else $error("start did not reset the slave");
    AST_NACK_END: assert property (q.st == ST_MACK && rise && n.sda_f && !stop |=> q.st == ST_IDLE && q.sda_rel)
        else $error("read went on after nack");
    AST_BAD_ID: assert property (s_last_bit_in and (q.kind == KD_SLV && !slave_hit(byte_in, q.sel_f))
                                 |=> q.st == ST_IDLE ##1 q.sda_rel)
        else $error("foreign address acknowledged");
    AST_REG_RANGE: assert property (s_last_bit_in and (q.kind == KD_RA && byte_in > REG_ADDR_MAX)
                                    |=> q.st == ST_IDLE && $stable(q.reg_addr))
        else $error("illegal register address accepted");
    AST_MEM_ONLY_MEM: assert property (q.mem_we |-> !q.tgt_reg && q.kind == KD_DAT && q.st == ST_ACKW)
        else $error("memory written outside a memory data byte");
    AST_ACK_DRIVE: assert property (q.st == ST_ACK |-> !sda_oe_n_o && !sda_o)
        else $error("acknowledge not driven");
    AST_WR_INC: assert property (q.mem_we |-> q.mem_addr == q.wr_addr + 15'h0001)
        else $error("memory address not advanced on write");
    AST_REG_KEEP: assert property (q.tgt_reg && !start |=> $stable(q.mem_addr))
        else $error("register access moved memory address");
    AST_FIRST_BIT: assert property (s_rd_addr_acked |=> q.st == ST_TX && q.sda_rel == $past(rd_sel[7]))
        else $error("read data not started after address acknowledge");
endmodule : dts_slave
`default_nettype wire

// ### include/dts_pkg.sv
// constants and enumerations of the dual-target two-wire slave
// assumes one 200 MHz clock; bus pins are asynchronous to it
package dts_pkg;
    // ----------------------------------------------------------
    // slave identifiers and address spaces
    // ----------------------------------------------------------
    localparam logic [3:0] MEM_ID       = 4'ha;
    localparam logic [3:0] REG_ID       = 4'hd;
    localparam int         MEM_AW       = 15;
    localparam int         MEM_DEPTH    = 32768;
    localparam int         REG_AW       = 5;
    localparam logic [7:0] REG_ADDR_MAX = 8'h18;
    localparam logic [4:0] REG_ADDR_TOP = 5'h18;
    // ----------------------------------------------------------
    // bit counter and values after reset
    // ----------------------------------------------------------
    localparam logic [2:0]        BIT_LAST     = 3'h7;
    localparam logic [2:0]        CNT_RST      = 3'h0;
    localparam logic [MEM_AW-1:0] MEM_ADDR_RST = 15'h0000;
    localparam logic [REG_AW-1:0] REG_ADDR_RST = 5'h00;
    localparam logic              LINE_RST     = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACKW = 3'b010,
        ST_ACK  = 3'b011,
        ST_TX   = 3'b100,
        ST_MACK = 3'b101,
        ST_LD   = 3'b110
    } dts_st_t;

    typedef enum logic [2:0] {
        KD_SLV = 3'b000,
        KD_AH  = 3'b001,
        KD_AL  = 3'b010,
        KD_RA  = 3'b011,
        KD_DAT = 3'b100
    } dts_kind_t;
endpackage : dts_pkg

// ### testbench/dts_mst.sv
// two-wire bus master model: drives the clock and data pins, samples the wire
// assumes the data wire is pulled up and the bench clock paces every level
`timescale 1ns/100ps
`default_nettype none
module dts_mst (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // 12 clk per step, above the 4 clk that the synchronisers need
    task automatic hp();
        repeat (12) @(posedge clk_i);
    endtask : hp
    // data moves a full step away from clock edges, never with them
    task automatic bw(input logic b);
        hp();
        sda_o <= b;
        hp();
        scl_o <= 1'b1;
        hp();
        scl_o <= 1'b0;
    endtask : bw
    task automatic br(output logic b);
        hp();
        sda_o <= 1'b1;
        hp();
        scl_o <= 1'b1;
        hp();
        b = sda_i;
        scl_o <= 1'b0;
    endtask : br
    task automatic start();
        hp();
        sda_o <= 1'b1;
        hp();
        scl_o <= 1'b1;
        hp();
        sda_o <= 1'b0;
        hp();
        scl_o <= 1'b0;
    endtask : start
    task automatic stop();
        hp();
        sda_o <= 1'b0;
        hp();
        scl_o <= 1'b1;
        hp();
        sda_o <= 1'b1;
    endtask : stop
    task automatic wb(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bw(d[i]);
        br(b);
        ack = ~b;
    endtask : wb
    task automatic rb(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) br(d[i]);
        bw(last);
    endtask : rb
endmodule : dts_mst
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench of the two-target slave with a bus master model
// assumes the register file sits outside the slave, modelled here
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import dts_pkg::*;
    logic             clk_i, sys_rst_i, scl, msda, sda_o, sda_oe_n_o, reg_we_o;
    logic [1:0]       sel_i;
    logic [REG_AW-1:0] reg_addr_o;
    logic [7:0]       reg_wdata_o, reg_rdata_i, regs [0:24], er [0:24];
    logic [7:0]       em [int];
    logic [15:0]      lf = 16'hadf2;
    int               errors, total_checks, ma, ra;
    wire              sda = msda & (sda_oe_n_o | sda_o);
    dts_mst m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(msda));
    dts_slave dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .sel_i(sel_i), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
        .reg_we_o(reg_we_o), .reg_rdata_i(reg_rdata_i));
    assign reg_rdata_i = regs[reg_addr_o];
    // the pulse shows the address already stepped on, so write one below
    always @(posedge clk_i) begin
        if (reg_we_o) regs[(reg_addr_o == 5'h00) ? REG_ADDR_TOP : reg_addr_o - 5'h01] <= reg_wdata_o;
    end
    function automatic logic [7:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf[7:0];
    endfunction : rnd
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    // rg picks the register target, set loads an address first
    task automatic xfer(input logic rg, input logic rd, input logic set, input int a, input int n);
        logic [3:0] id = rg ? REG_ID : MEM_ID;
        logic       ack;
        logic [7:0] d;
        m.start();
        if (set) begin
            m.wb({id, 1'b0, sel_i, 1'b0}, ack);
            chk(8'(ack), 8'h01);
            if (!rg) begin
                m.wb((rnd() & 8'h80) | 8'(a >> 8), ack);
                chk(8'(ack), 8'h01);
                ma = a;
            end else ra = a;
            m.wb(8'(a), ack);
            chk(8'(ack), 8'h01);
            if (rd) m.start();
        end
        if (rd) begin
            m.wb({id, 1'b0, sel_i, 1'b1}, ack);
            chk(8'(ack), 8'h01);
        end
        for (int i = 0; i < n; i++) begin
            if (rd) m.rb(i == n - 1, d);
            else begin
                d = rnd();
                m.wb(d, ack);
                chk(8'(ack), 8'h01);
            end
            if (rg) begin
                if (rd) chk(d, er[ra]);
                else er[ra] = d;
                ra = (ra == 24) ? 0 : ra + 1;
            end else begin
                if (rd && em.exists(ma)) chk(d, em[ma]);
                if (!rd) em[ma] = d;
                ma = (ma + 1) % MEM_DEPTH;
            end
        end
        m.stop();
    endtask : xfer
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (90000) @(posedge clk_i);
        errors++;
        stop_test();
    end
    initial begin
        logic       ack, ack2;
        logic [7:0] d;
        int         a;
        sys_rst_i = 1'b1;
        sel_i = 2'b00;
        for (int i = 0; i < 25; i++) begin
            regs[i] = rnd();
            er[i] = regs[i];
        end
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        sel_i <= 2'(rnd());
        xfer(1'b0, 1'b0, 1'b1, 'h7ffe, 4);
        xfer(1'b0, 1'b1, 1'b1, 'h7ffe, 2);
        a = rnd() % 25;
        xfer(1'b1, 1'b0, 1'b1, a, 3);
        xfer(1'b1, 1'b1, 1'b1, a, 3);
        xfer(1'b0, 1'b1, 1'b0, 0, 2);
        for (int k = 0; k < 3; k++) begin
            a = {rnd(), rnd()} % MEM_DEPTH;
            xfer(1'b0, 1'b0, 1'b1, a, 1 + k);
            xfer(1'b0, 1'b1, 1'b1, a, 1 + k);
        end
        // every select value against known and foreign identifiers
        foreach (em[i]) d = d;
        for (int k = 0; k < 16; k++) begin
            a = (k >> 2 == 0) ? MEM_ID : (k >> 2 == 1) ? REG_ID : (k >> 2 == 2) ? 4'h2 : 4'hb;
            m.start();
            m.wb({4'(a), 1'b0, 2'(k), 1'b0}, ack);
            m.wb(8'h00, ack2);
            m.stop();
            chk(8'(ack), 8'((k < 8) && (2'(k) == sel_i)));
            chk(8'(ack2), 8'((k < 8) && (2'(k) == sel_i)));
        end
        ra = 0;
        foreach (er[i]) d = d;
        for (int k = 0; k < 3; k++) begin
            m.start();
            m.wb({REG_ID, 1'b0, sel_i, 1'b0}, ack);
            m.wb((k == 0) ? 8'h19 : (k == 1) ? 8'hff : (8'h19 | rnd()), ack);
            m.wb(8'h00, ack2);
            m.stop();
            chk(8'({ack, ack2}), 8'h00);
        end
        // the select loop loaded register address 0; refused loads kept it
        ra = 0;
        xfer(1'b1, 1'b1, 1'b0, 0, 1);
        // write cut short after its fifth bit, then read the same place
        a = 'h7ffe;
        m.start();
        m.wb({MEM_ID, 1'b0, sel_i, 1'b0}, ack);
        m.wb(8'h7f, ack);
        m.wb(8'hfe, ack);
        for (int i = 0; i < 5; i++) begin
            d = rnd();
            m.bw(d[0]);
        end
        m.start();
        m.wb({MEM_ID, 1'b0, sel_i, 1'b1}, ack);
        m.rb(1'b1, d);
        chk(d, em[a]);
        for (int i = 7; i >= 0; i--) m.br(d[i]);
        chk(d, 8'hff);
        m.stop();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
